/* File: shared/pdb_pkg.sv */
/*
 * Constants and types shared by the dead-band inserter: register offsets,
 * field positions, reset values, generator action codes and decode selects.
 * Assumes a 32-bit APB with 12-bit byte addresses local to the PWM block.
 */
`default_nettype none

package pdb_pkg;

    // =========================================================================
    // Bus geometry
    localparam int unsigned PDB_ADDR_W = 12;
    localparam int unsigned PDB_DATA_W = 32;
    localparam int unsigned PDB_DELAY_W = 12;

    // =========================================================================
    // Register byte offsets
    localparam logic [11:0] PDB_CTRL_OFS = 12'h068;
    localparam logic [11:0] PDB_RISE_OFS = 12'h06c;
    localparam logic [11:0] PDB_FALL_OFS = 12'h070;

    // =========================================================================
    // Field positions and reset values
    localparam int unsigned PDB_ENABLE_BIT = 0;
    localparam logic PDB_ENABLE_RST = 1'b0;
    localparam logic [11:0] PDB_RISE_RST = 12'h000;
    localparam logic [11:0] PDB_FALL_RST = 12'h000;
    localparam logic [11:0] PDB_CNT_MAX = 12'hfff;
    localparam logic [11:0] PDB_HIGH_CNT_RST = 12'h000;
    localparam logic [11:0] PDB_LOW_CNT_RST = 12'hfff;
    localparam logic PDB_GEN_RST = 1'b0;

    // =========================================================================
    // Per-event generator actions
    typedef enum logic [1:0] {
        PDB_ACT_NONE = 2'b00,
        PDB_ACT_INVERT = 2'b01,
        PDB_ACT_LOW = 2'b10,
        PDB_ACT_HIGH = 2'b11
    } pdb_action_t;

    // =========================================================================
    // Register decode result
    typedef enum logic [1:0] {
        PDB_SEL_NONE,
        PDB_SEL_CTRL,
        PDB_SEL_RISE,
        PDB_SEL_FALL
    } pdb_sel_t;

endpackage

`default_nettype wire

/* File: src/pdb_dead_band.sv */
/*
 * Dead-band inserter for one PWM generator pair, with its three registers
 * on an APB slave port and the two generator signals built from actions.
 * Assumes the action inputs and the APB master run on SYS_CLK_I.
 */
// Our own choice: the APB slave port.
// Behaviour
// RULE1: Disabled: A to first, B to second output
// RULE2: Enabled: input B ignored, both from A
// RULE3: First output delays rising edges of A
// RULE4: Second output delays falling edges of A
// RULE5: Control bit 0 enables insertion, resets 0
// RULE6: Rising delay field bits 11:0, resets 0
// RULE7: Falling delay field bits 11:0, resets 0
// RULE8: Disabled outputs ignore both delay registers
// RULE9: Rise delay beyond high pulse: no high
// RULE10: Fall delay beyond low pulse: no low
// RULE11: Software keeps pulses longer than delays
// RULE12: Reserved upper bits: read indeterminate, preserve
// RULE13: Generator actions: none, invert, low, high
// RULE14: Exact delay; opposite edge cancels pending edge
// RULE15: Zero delay adds only pipeline stage
`timescale 1ns/1ps
`default_nettype none

module pdb_dead_band
    import pdb_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [1:0] GEN_INPUT_A_ACTION_I,
    input wire logic [1:0] GEN_INPUT_B_ACTION_I,
    output logic FIRST_OUTPUT_O,
    output logic SECOND_OUTPUT_O
);

    // =========================================================================
    // State
    typedef struct packed {
        logic enable;
        logic [11:0] rise_tick_count;
        logic [11:0] fall_tick_count;
        logic gen_a;
        logic gen_b;
        logic [11:0] high_cnt;
        logic [11:0] low_cnt;
        logic first_out;
        logic second_out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pdb_state_t;

    pdb_state_t s_q;
    pdb_state_t s_d;

    // =========================================================================
    // Helpers
    function automatic logic apply_action(input logic level, input logic [1:0] act);
        logic res;
        res = level;
        case (pdb_action_t'(act))
            PDB_ACT_NONE: res = level;
            PDB_ACT_INVERT: res = ~level;
            PDB_ACT_LOW: res = 1'b0;
            PDB_ACT_HIGH: res = 1'b1;
            default: res = level;
        endcase
        return res;
    endfunction

    // Saturation keeps a long steady input from wrapping back under the delay
    function automatic logic [11:0] sat_inc(input logic [11:0] cnt);
        logic [11:0] res;
        res = cnt;
        if (cnt != PDB_CNT_MAX) begin
            res = cnt + 12'h001;
        end
        return res;
    endfunction

    function automatic pdb_sel_t decode(input logic [11:0] addr);
        pdb_sel_t sel;
        sel = PDB_SEL_NONE;
        if (addr == PDB_CTRL_OFS) begin
            sel = PDB_SEL_CTRL;
        end else if (addr == PDB_RISE_OFS) begin
            sel = PDB_SEL_RISE;
        end else if (addr == PDB_FALL_OFS) begin
            sel = PDB_SEL_FALL;
        end
        return sel;
    endfunction

    logic apb_access;
    logic apb_answer;
    logic apb_commit;
    pdb_sel_t apb_sel;

    assign apb_access = PSEL_I & PENABLE_I;
    assign apb_answer = apb_access & ~s_q.pready;
    assign apb_commit = apb_access & s_q.pready;
    assign apb_sel = decode(PADDR_I);

    // =========================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.gen_a = apply_action(s_q.gen_a, GEN_INPUT_A_ACTION_I); // RULE13
        s_d.gen_b = apply_action(s_q.gen_b, GEN_INPUT_B_ACTION_I); // RULE13

        // Run lengths of the current level of A; the other one restarts at zero
        s_d.high_cnt = s_q.gen_a ? sat_inc(s_q.high_cnt) : 12'h000; // RULE14
        s_d.low_cnt = s_q.gen_a ? 12'h000 : sat_inc(s_q.low_cnt); // RULE14

        if (s_q.enable) begin
            // A short pulse never reaches its count, so it is swallowed whole
            s_d.first_out = s_q.gen_a & (s_q.high_cnt >= s_q.rise_tick_count); // RULE2 RULE3 RULE9 RULE15
            s_d.second_out = s_q.gen_a | (s_q.low_cnt < s_q.fall_tick_count); // RULE2 RULE4 RULE10 RULE15
        end else begin
            s_d.first_out = s_q.gen_a; // RULE1 RULE8
            s_d.second_out = s_q.gen_b; // RULE1 RULE8
        end

        // One wait state: answer in the second access cycle, commit at its edge
        s_d.pready = apb_answer;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (apb_answer) begin
            case (apb_sel)
                PDB_SEL_CTRL: s_d.prdata = {31'h00000000, s_q.enable}; // RULE12
                PDB_SEL_RISE: s_d.prdata = {20'h00000, s_q.rise_tick_count}; // RULE12
                PDB_SEL_FALL: s_d.prdata = {20'h00000, s_q.fall_tick_count}; // RULE12
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (apb_commit & PWRITE_I) begin
            case (apb_sel)
                PDB_SEL_CTRL: s_d.enable = PWDATA_I[PDB_ENABLE_BIT]; // RULE5
                PDB_SEL_RISE: s_d.rise_tick_count = PWDATA_I[11:0]; // RULE6
                PDB_SEL_FALL: s_d.fall_tick_count = PWDATA_I[11:0]; // RULE7
                default: s_d.enable = s_q.enable;
            endcase
        end
    end

    // =========================================================================
    // Registers
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            s_q.enable <= PDB_ENABLE_RST; // RULE5
            s_q.rise_tick_count <= PDB_RISE_RST; // RULE6
            s_q.fall_tick_count <= PDB_FALL_RST; // RULE7
            s_q.gen_a <= PDB_GEN_RST;
            s_q.gen_b <= PDB_GEN_RST;
            s_q.high_cnt <= PDB_HIGH_CNT_RST;
            // Starts saturated so the second output does not glitch high
            s_q.low_cnt <= PDB_LOW_CNT_RST;
            s_q.first_out <= 1'b0;
            s_q.second_out <= 1'b0;
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA_O = s_q.prdata;
    assign PREADY_O = s_q.pready;
    assign PSLVERR_O = s_q.pslverr;
    assign FIRST_OUTPUT_O = s_q.first_out;
    assign SECOND_OUTPUT_O = s_q.second_out;

    // =========================================================================
    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    property p_bypass_a;
        !s_q.enable |=> FIRST_OUTPUT_O == $past(s_q.gen_a);
    endproperty
    a_bypass_a: assert property (p_bypass_a) else $error("first output not equal to A in bypass"); // RULE1

    property p_bypass_b;
        !s_q.enable |=> SECOND_OUTPUT_O == $past(s_q.gen_b);
    endproperty
    a_bypass_b: assert property (p_bypass_b) else $error("second output not equal to B in bypass"); // RULE1 RULE8

    property p_b_ignored;
        s_q.enable && s_q.gen_b && !s_q.gen_a |=> !FIRST_OUTPUT_O;
    endproperty
    a_b_ignored: assert property (p_b_ignored) else $error("input B reached first output"); // RULE2

    property p_rise_three;
        ($rose(s_q.gen_a) && s_q.enable && s_q.rise_tick_count == 12'h003)
            ##1 (s_q.gen_a && s_q.enable && s_q.rise_tick_count == 12'h003) [*3]
            |=> FIRST_OUTPUT_O && !$past(FIRST_OUTPUT_O);
    endproperty
    a_rise_three: assert property (p_rise_three) else $error("rising edge not delayed by three ticks"); // RULE3

    property p_fall_two;
        ($fell(s_q.gen_a) && s_q.enable && s_q.fall_tick_count == 12'h002)
            ##1 (!s_q.gen_a && s_q.enable && s_q.fall_tick_count == 12'h002) [*2]
            |=> !SECOND_OUTPUT_O && $past(SECOND_OUTPUT_O);
    endproperty
    a_fall_two: assert property (p_fall_two) else $error("falling edge not delayed by two ticks"); // RULE4

    property p_rise_exact;
        s_q.enable && $rose(s_d.first_out) |-> s_q.high_cnt == s_q.rise_tick_count;
    endproperty
    a_rise_exact: assert property (p_rise_exact) else $error("first output rose at wrong count"); // RULE14

    property p_low_kills_first;
        s_q.enable && !s_q.gen_a |=> !FIRST_OUTPUT_O;
    endproperty
    a_low_kills_first: assert property (p_low_kills_first) else $error("first output high while A low"); // RULE9

    property p_high_keeps_second;
        s_q.enable && s_q.gen_a |=> SECOND_OUTPUT_O;
    endproperty
    a_high_keeps_second: assert property (p_high_keeps_second) else $error("second output low while A high"); // RULE10

    property p_zero_delay;
        s_q.enable && s_q.rise_tick_count == 12'h000 && s_q.gen_a |=> FIRST_OUTPUT_O;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero rise delay added latency"); // RULE15

    property p_enable_by_write;
        $changed(s_q.enable) |-> $past(apb_commit && PWRITE_I && apb_sel == PDB_SEL_CTRL);
    endproperty
    a_enable_by_write: assert property (p_enable_by_write) else $error("enable changed without write"); // RULE5

    property p_rise_by_write;
        $changed(s_q.rise_tick_count) |-> $past(s_q.pready && PWRITE_I && PADDR_I == PDB_RISE_OFS);
    endproperty
    a_rise_by_write: assert property (p_rise_by_write) else $error("rise delay changed without write"); // RULE6

    property p_fall_by_write;
        $changed(s_q.fall_tick_count) |-> $past(s_q.pready && PWRITE_I && PADDR_I == PDB_FALL_OFS);
    endproperty
    a_fall_by_write: assert property (p_fall_by_write) else $error("fall delay changed without write"); // RULE7

    property p_ctrl_read_upper;
        apb_answer && !PWRITE_I && apb_sel == PDB_SEL_CTRL |=> PREADY_O && PRDATA_O[31:1] == 31'h00000000;
    endproperty
    a_ctrl_read_upper: assert property (p_ctrl_read_upper) else $error("control read upper bits not zero"); // RULE12

    property p_ready_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

    property p_ready_bound;
        $rose(apb_access) |-> ##1 PREADY_O;
    endproperty
    a_ready_bound: assert property (p_ready_bound) else $error("no answer one cycle into access");

    property p_rise_upper;
        apb_answer && !PWRITE_I && apb_sel == PDB_SEL_RISE |=> PREADY_O && PRDATA_O[31:12] == 20'h00000;
    endproperty
    a_rise_upper: assert property (p_rise_upper) else $error("rise delay read upper bits not zero"); // RULE6 RULE12

    property p_fall_upper;
        apb_answer && !PWRITE_I && apb_sel == PDB_SEL_FALL |=> PREADY_O && PRDATA_O[31:12] == 20'h00000;
    endproperty
    a_fall_upper: assert property (p_fall_upper) else $error("fall delay read upper bits not zero"); // RULE7 RULE12

    property p_unmapped_err;
        apb_answer && apb_sel == PDB_SEL_NONE |=> PSLVERR_O && PRDATA_O == 32'h00000000;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

    // Data and error must read as quiet outside the answer cycle
    property p_idle_quiet;
        !PREADY_O |-> !PSLVERR_O && PRDATA_O == 32'h00000000;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("bus response outside ready cycle");

    property p_act_invert;
        GEN_INPUT_A_ACTION_I == PDB_ACT_INVERT |=> s_q.gen_a != $past(s_q.gen_a);
    endproperty
    a_act_invert: assert property (p_act_invert) else $error("invert action did not flip A"); // RULE13

    property p_act_high;
        GEN_INPUT_A_ACTION_I == PDB_ACT_HIGH |=> s_q.gen_a;
    endproperty
    a_act_high: assert property (p_act_high) else $error("high action did not set A"); // RULE13

    property p_act_low;
        GEN_INPUT_B_ACTION_I == PDB_ACT_LOW |=> !s_q.gen_b;
    endproperty
    a_act_low: assert property (p_act_low) else $error("low action did not clear B"); // RULE13

    // Enable must be steady over both cycles, or a bypass level would look like an edge
    property p_fall_exact;
        $past(s_q.enable) && s_q.enable && $fell(s_d.second_out) |-> s_q.low_cnt == s_q.fall_tick_count;
    endproperty
    a_fall_exact: assert property (p_fall_exact) else $error("second output fell at wrong count"); // RULE14

endmodule

`default_nettype wire

/* File: testbench/pdb_gen_model.sv */
/*
 * Upstream generator stand-in: turns wanted levels for A and B into the
 * per-cycle action codes, tracking the level the design's generators hold.
 * Assumes the design applies an action at the edge after it is presented.
 */
`timescale 1ns/1ps
`default_nettype none

module pdb_gen_model
    import pdb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic want_a_i,
    input wire logic want_b_i,
    input wire logic use_inv_i,
    output logic [1:0] act_a_o,
    output logic [1:0] act_b_o
);
    // =========================================================================
    // Action selection
    logic lvl_a_q, lvl_b_q, nl_a, nl_b;

    function automatic logic apply(logic [1:0] act, logic lvl);
        case (act)
            PDB_ACT_INVERT: return !lvl;
            PDB_ACT_LOW: return 1'b0;
            PDB_ACT_HIGH: return 1'b1;
            default: return lvl;
        endcase
    endfunction

    // Levels are only ever moved on request, so pulse widths stay as asked
    function automatic logic [1:0] pick(logic want, logic lvl, logic inv);
        if (want == lvl) return PDB_ACT_NONE;
        if (inv) return PDB_ACT_INVERT;
        return want ? PDB_ACT_HIGH : PDB_ACT_LOW;
    endfunction

    // Look ahead one action so an invert is never issued twice
    always_comb begin
        nl_a = apply(act_a_o, lvl_a_q);
        nl_b = apply(act_b_o, lvl_b_q);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_a_o <= PDB_ACT_NONE;
            act_b_o <= PDB_ACT_NONE;
            lvl_a_q <= 1'b0;
            lvl_b_q <= 1'b0;
        end else begin
            act_a_o <= pick(want_a_i, nl_a, use_inv_i);
            act_b_o <= pick(want_b_i, nl_b, use_inv_i);
            lvl_a_q <= nl_a;
            lvl_b_q <= nl_b;
        end
    end
endmodule

`default_nettype wire

/* File: testbench/pwm_dead_band_inserter_tb.sv */
/*
 * Self-checking bench for the dead-band inserter: APB register access,
 * bypass routing and delayed edges timed from the wanted input change.
 * Assumes the one-wait-state APB slave and two-cycle generator latency.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module pwm_dead_band_inserter_tb;
    import pdb_pkg::*;
    // =========================================================================
    // Signals
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, wa = 0, wb = 0, inv = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic pready, pslverr, erv, first, second;
    logic [1:0] act_a, act_b;
    int error_cnt = 0, checks = 0, n1, n2;

    always #2 clk = ~clk;

    pdb_gen_model gen (.clk_i(clk), .rst_i(rst), .want_a_i(wa), .want_b_i(wb), .use_inv_i(inv),
        .act_a_o(act_a), .act_b_o(act_b));
    pdb_dead_band uut (.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .GEN_INPUT_A_ACTION_I(act_a), .GEN_INPUT_B_ACTION_I(act_b),
        .FIRST_OUTPUT_O(first), .SECOND_OUTPUT_O(second));

    // =========================================================================
    // Helpers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        erv = pslverr;
        psel <= 0;
        pen <= 0;
        if (n >= 50) begin
            error_cnt++;
            $display("[FAIL] apb_ready exp 1 got %0b", pready);
        end
        @(posedge clk);
    endtask

    task automatic wt(input logic v, input bit sec, output int n);
        n = 0;
        while (((sec ? second : first) !== v) && n < 5000) begin @(negedge clk); n++; end
    endtask

    task automatic cfg(input logic en, input logic [11:0] d, input logic [11:0] f);
        apb(1, PDB_CTRL_OFS, {31'h0, en});
        apb(1, PDB_RISE_OFS, {20'h0, d});
        apb(1, PDB_FALL_OFS, {20'h0, f});
        repeat (20) @(posedge clk);
    endtask

    // =========================================================================
    // Scenarios
    task automatic t_regs;
        logic [11:0] ofs[3] = '{PDB_CTRL_OFS, PDB_RISE_OFS, PDB_FALL_OFS};
        logic [31:0] msk[3] = '{32'h1, 32'hfff, 32'hfff};
        for (int i = 0; i < 3; i++) begin
            apb(0, ofs[i], 32'h0);
            `CHK("reg_reset", 32'h0, rdv)
            apb(1, ofs[i], msk[i]);
            apb(0, ofs[i], 32'h0);
            `CHK("reg_rw", msk[i], rdv)
            `CHK("mapped_ok", 1'b0, erv)
        end
        apb(0, 12'h074, 32'h0);
        `CHK("unmapped_err", 1'b1, erv)
        `CHK("unmapped_data", 32'h0, rdv)
        apb(1, 12'h074, 32'h0);
        `CHK("unmapped_wr_err", 1'b1, erv)
        apb(0, PDB_CTRL_OFS, 32'h0);
        `CHK("unmapped_wr_ignored", 32'h1, rdv)
    endtask

    task automatic t_bypass;
        cfg(1'b0, 12'h007, 12'h007);
        wa <= 1; wb <= 0; inv <= 1;
        repeat (3) @(negedge clk);
        `CHK("bypass_lag", 1'b0, first)
        @(negedge clk);
        `CHK("bypass_a", 1'b1, first)
        `CHK("bypass_b", 1'b0, second)
        @(posedge clk);
        wa <= 0; wb <= 1;
        repeat (4) @(negedge clk);
        `CHK("bypass_a0", 1'b0, first)
        `CHK("bypass_b1", 1'b1, second)
        @(posedge clk);
        inv <= 0;
    endtask

    task automatic t_dly(input logic [11:0] d, input logic [11:0] f);
        cfg(1'b1, d, f);
        wa <= 1; wb <= !wb;
        wt(1'b1, 1'b1, n1);
        wt(1'b1, 1'b0, n2);
        `CHK("second_rise", 4, n1)
        `CHK("rise_delay", 4 + int'(d), n1 + n2)
        @(posedge clk);
        wa <= 0; wb <= !wb;
        wt(1'b0, 1'b0, n1);
        wt(1'b0, 1'b1, n2);
        `CHK("first_fall", 4, n1)
        `CHK("fall_delay", 4 + int'(f), n1 + n2)
        // Back onto a rising edge so the next bus request starts there
        @(posedge clk);
    endtask

    task automatic t_swallow;
        logic seen;
        cfg(1'b1, 12'h006, 12'h006);
        wa <= 1;
        repeat (4) @(posedge clk);
        wa <= 0;
        seen = 0;
        repeat (20) begin @(negedge clk); seen |= first; end
        `CHK("no_high", 1'b0, seen)
        @(posedge clk);
        wa <= 1;
        repeat (20) @(posedge clk);
        wa <= 0;
        repeat (4) @(posedge clk);
        wa <= 1;
        seen = 1;
        repeat (20) begin @(negedge clk); seen &= second; end
        `CHK("no_low", 1'b1, seen)
    endtask

    // =========================================================================
    // Sequence and verdict
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_regs;
        t_bypass;
        t_dly(12'h000, 12'h000);
        t_dly(12'h005, 12'h009);
        t_dly(12'h003, 12'h002);
        t_swallow;
        wrap_up;
    end

    // Whole run is a few hundred cycles; this limit is far beyond it
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] watchdog exp finished got timeout");
        wrap_up;
    end
endmodule

`default_nettype wire
